//--- mph_fifo.sv
// small valid/ready buffer in the receive data path
`timescale 1ns/100ps
module mph_fifo import mph_pkg::*; #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refuse sizes that the wrap-bit pointers cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
    $error("mph_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_next;
  logic ready_reg;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  function automatic logic is_full(input logic [AW:0] wp, input logic [AW:0] rp);
    return (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  endfunction

  // ready is a flop worked out one step ahead, so the port output has no logic path
  assign in_ready = ready_reg;
  assign wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
  assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; empty pointers hide stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      ready_reg <= !is_full(wr_ptr_next, rd_ptr_next);
    end
  end
endmodule

//--- mph_mac_model.sv
// behavioural mac facing the phy-side port
`timescale 1ns/100ps
module mph_mac_model import mph_pkg::*; (
  // clock and mode
  input wire logic core_clk,
  input wire logic rmii_mode,
  // pins from the phy
  input wire logic tx_nibble_clock,
  input wire logic rx_nibble_clock,
  input wire logic [3:0] rx_nibble_bus,
  input wire logic rx_data_valid,
  input wire logic rx_error_in,
  // pins to the phy, and the management data drive and enable from it
  output logic [3:0] tx_nibble_bus,
  output logic tx_enable_out,
  output logic mgmt_clock_out,
  output logic mgmt_data_io_in,
  input wire logic mgmt_data_io_out,
  input wire logic mgmt_data_io_oe
);
  logic [3:0] tx_q[$];
  logic [3:0] rx_q[$];
  logic crc_q[$];
  logic mg_q[$];
  logic rd_q[$];
  int bad_end = 0;
  int mdiv = 0;
  logic run_mdc = 1'b0;
  logic tclk_q = 1'b0, rclk_q = 1'b0, mdc_drv = 1'b1, half_tx = 1'b0, half_rx = 1'b0, in_frame = 1'b0, err_seen = 1'b0;
  logic [3:0] cur, acc;
  // rmii times both directions from the reference clock
  wire tclk = rmii_mode ? rx_nibble_clock : tx_nibble_clock;
  // pull-up wins when nobody drives the management line
  assign mgmt_data_io_in = mgmt_data_io_oe ? mgmt_data_io_out : mdc_drv;
  initial {tx_nibble_bus, tx_enable_out, mgmt_clock_out} = 6'h0;
  // transmit: next nibble or dibit just after each falling link edge; idle lines keep toggling
  always @(posedge core_clk) begin
    tclk_q <= tclk;
    if (tclk_q && !tclk) begin
      if (half_tx) begin
        tx_nibble_bus <= {~tx_nibble_bus[3:2], cur[3:2]};
        half_tx <= 1'b0;
      end else if (tx_q.size() > 0) begin
        cur = tx_q.pop_front();
        tx_nibble_bus <= rmii_mode ? {~tx_nibble_bus[3:2], cur[1:0]} : cur;
        tx_enable_out <= 1'b1;
        half_tx <= rmii_mode;
      end else begin
        tx_enable_out <= 1'b0;
        tx_nibble_bus <= ~tx_nibble_bus;
      end
    end
  end
  // receive: sample on rising link edge, fold dibits low first, close the frame when valid drops
  always @(posedge core_clk) begin
    rclk_q <= rx_nibble_clock;
    if (!rclk_q && rx_nibble_clock) begin
      if (rx_data_valid) begin
        err_seen <= err_seen | rx_error_in;
        in_frame <= 1'b1;
        if (rmii_mode && !half_rx) acc[1:0] <= rx_nibble_bus[1:0];
        else rx_q.push_back(rmii_mode ? {rx_nibble_bus[1:0], acc[1:0]} : rx_nibble_bus);
        half_rx <= rmii_mode && !half_rx;
      end else if (in_frame) begin
        crc_q.push_back(err_seen | rx_error_in);
        if (half_rx) bad_end <= bad_end + 1;
        {in_frame, err_seen, half_rx} <= 3'h0;
      end
    end
  end
  // management clock runs only on request; our bit changes on its fall, read on its rise
  always @(posedge core_clk) begin
    mdiv <= (mdiv + 1) % 16;
    if (mdiv == 0 && run_mdc) begin
      mgmt_clock_out <= 1'b1;
      rd_q.push_back(mgmt_data_io_in);
    end
    if (mdiv == 8 && mgmt_clock_out) begin
      mgmt_clock_out <= 1'b0;
      mdc_drv <= mg_q.size() > 0 ? mg_q.pop_front() : 1'b1;
    end
  end
endmodule

//--- mph_params.svh
// timing counts, error stretch and buffer layout for the phy-side port of a mii/rmii link
// What this block does
// - management bits latched on management clock rise
// - management data line carries both directions
// - collision held asserted while collision lasts
// - mii transmit clock is 25 or 2.5 mhz
// - mii transmit nibble sampled on clock rise
// - mii receive clock is 25 or 2.5 mhz
// - rmii reference clock is 50 mhz
// - receive nibble meaningful only while valid high
// - receive valid high through frame, low after
// - rmii carrier-valid high while medium busy
// - carrier-valid drops only on nibble boundary
// - receive error held longer than one clock
`ifndef MPH_PARAMS_SVH
`define MPH_PARAMS_SVH

// ****************************************************************
// core clock and link clock periods
// ****************************************************************
`define MPH_CORE_CLK_NS 5
`define MPH_MII_FAST_NS 40
`define MPH_MII_SLOW_NS 400
`define MPH_RMII_REF_NS 20
// half periods in core cycles, rounded down so the link is never slow
`define MPH_HALF_FAST ((`MPH_MII_FAST_NS / 2) / `MPH_CORE_CLK_NS)
`define MPH_HALF_SLOW ((`MPH_MII_SLOW_NS / 2) / `MPH_CORE_CLK_NS)
`define MPH_HALF_REF ((`MPH_RMII_REF_NS / 2) / `MPH_CORE_CLK_NS)

// ****************************************************************
// receive error stretch and buffer layout
// ****************************************************************
`define MPH_ERR_SLOTS 2
`define MPH_ENT_NIB_LSB 0
`define MPH_ENT_ERR_BIT 4
`define MPH_ENT_LAST_BIT 5
`define MPH_ENT_W 6

`endif

//--- mph_phy_port.sv
// phy-side model of one mii/rmii link: makes link clocks, sends receive frames, captures transmit data
`timescale 1ns/100ps
`include "mph_params.svh"
module mph_phy_port import mph_pkg::*; #(
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // configuration
  input wire logic rmii_mode,
  input wire logic slow_speed,
  // receive frame source (nibble, error, last)
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [3:0] rx_in_nibble,
  input wire logic rx_in_error,
  input wire logic rx_in_last,
  // medium events
  input wire logic collision_req,
  // captured transmit data
  output logic tx_out_valid,
  output logic [3:0] tx_out_nibble,
  output logic tx_out_active,
  // management bits seen from the mac, and the bit and enable to drive back to it
  output logic mgmt_bit_valid,
  output logic mgmt_bit,
  input wire logic mgmt_drive_en,
  input wire logic mgmt_drive_bit,
  // link pins from the mac, and the management data drive and enable to it
  input wire logic mgmt_clock_out,
  input wire logic mgmt_data_io_in,
  output logic mgmt_data_io_out,
  output logic mgmt_data_io_oe,
  input wire logic [3:0] tx_nibble_bus,
  input wire logic tx_enable_out,
  // link pins to the mac
  output logic tx_nibble_clock,
  output logic rx_nibble_clock,
  output logic [3:0] rx_nibble_bus,
  output logic rx_data_valid,
  output logic rx_error_in,
  output logic collision_in,
  output logic carrier_sense_in
);
  // ****************************************************************
  // link clock divider
  // ****************************************************************
  logic [7:0] half_cnt_reg;
  logic [7:0] half_len;
  logic link_clk_reg;
  logic wrap;
  logic rise_en;
  logic fall_en;

  // one divider serves every mode; rmii runs both directions from it
  assign half_len = rmii_mode ? 8'(`MPH_HALF_REF) : (slow_speed ? 8'(`MPH_HALF_SLOW) : 8'(`MPH_HALF_FAST));
  assign wrap = (half_cnt_reg >= half_len - 8'h01);
  assign rise_en = wrap && !link_clk_reg;
  assign fall_en = wrap && link_clk_reg;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      half_cnt_reg <= 8'h00;
      link_clk_reg <= 1'b0;
    end else if (wrap) begin
      half_cnt_reg <= 8'h00;
      link_clk_reg <= !link_clk_reg;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // clock pins; tx clock parks high in rmii like the pull-up it stands for
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_nibble_clock <= 1'b0;
      rx_nibble_clock <= 1'b0;
    end else begin
      tx_nibble_clock <= rmii_mode ? 1'b1 : (link_clk_reg ^ wrap);
      rx_nibble_clock <= link_clk_reg ^ wrap;
    end
  end

  // ****************************************************************
  // receive path: buffer and frame sender
  // ****************************************************************
  logic [`MPH_ENT_W-1:0] ent_in;
  logic [`MPH_ENT_W-1:0] ent_out;
  logic ent_valid;
  logic ent_pop;
  mph_rx_state_t rx_state_reg;
  logic dibit_phase_reg;
  logic [1:0] err_slots_reg;

  assign ent_in = {rx_in_last, rx_in_error, rx_in_nibble};

  mph_fifo #(.WIDTH(`MPH_ENT_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(rx_in_valid),
    .in_ready(rx_in_ready),
    .in_data(ent_in),
    .out_valid(ent_valid),
    .out_ready(ent_pop),
    .out_data(ent_out)
  );

  // a nibble leaves the buffer only once all its dibits went out
  assign ent_pop = fall_en && ent_valid && (rx_state_reg != MPH_RX_GAP) && (!rmii_mode || dibit_phase_reg);

  // frame sender: data changes on the falling link edge so the mac samples mid-bit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_state_reg <= MPH_RX_IDLE;
      dibit_phase_reg <= 1'b0;
      rx_nibble_bus <= 4'h0;
      rx_data_valid <= 1'b0;
    end else if (fall_en) begin
      case (rx_state_reg)
        MPH_RX_IDLE, MPH_RX_SEND: begin
          if (ent_valid) begin
            rx_data_valid <= 1'b1;
            if (rmii_mode) begin
              rx_nibble_bus <= {2'b00, dibit_phase_reg ? ent_out[3:2] : ent_out[1:0]};
              dibit_phase_reg <= !dibit_phase_reg;
            end else begin
              rx_nibble_bus <= ent_out[3:0];
            end
            rx_state_reg <= (ent_pop && ent_out[`MPH_ENT_LAST_BIT]) ? MPH_RX_GAP : MPH_RX_SEND;
          end else begin
            // underrun or idle: valid drops; in rmii only after a whole nibble
            rx_data_valid <= 1'b0;
            rx_nibble_bus <= 4'h0;
            dibit_phase_reg <= 1'b0;
            rx_state_reg <= MPH_RX_IDLE;
          end
        end
        MPH_RX_GAP: begin
          // one idle slot between frames, valid low from here
          rx_data_valid <= 1'b0;
          rx_nibble_bus <= 4'h0;
          dibit_phase_reg <= 1'b0;
          rx_state_reg <= MPH_RX_IDLE;
        end
        default: begin
          rx_state_reg <= MPH_RX_IDLE;
        end
      endcase
    end
  end

  // error stretch: an error nibble holds the pin for two link slots in mii and three dibit slots in rmii, so longer than one period
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      err_slots_reg <= 2'h0;
      rx_error_in <= 1'b0;
    end else if (fall_en) begin
      if (ent_valid && rx_state_reg != MPH_RX_GAP && ent_out[`MPH_ENT_ERR_BIT]) begin
        err_slots_reg <= 2'(`MPH_ERR_SLOTS - 1);
        rx_error_in <= 1'b1;
      end else if (err_slots_reg != 2'h0) begin
        err_slots_reg <= err_slots_reg - 2'h1;
        rx_error_in <= 1'b1;
      end else begin
        rx_error_in <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // transmit capture from the mac
  // ****************************************************************
  logic [4:0] tx_meta_reg;
  logic [4:0] tx_sync_reg;
  logic [1:0] rise_dly_reg;
  logic [1:0] low_dibit_reg;
  logic tx_phase_reg;

  // pins pass two flops; the capture strobe is delayed by the same two cycles
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_meta_reg <= 5'h00;
      tx_sync_reg <= 5'h00;
      rise_dly_reg <= 2'h0;
    end else begin
      tx_meta_reg <= {tx_enable_out, tx_nibble_bus};
      tx_sync_reg <= tx_meta_reg;
      rise_dly_reg <= {rise_dly_reg[0], rise_en};
    end
  end

  // sample at the rising link edge, as a phy latches the mac's nibble
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_out_valid <= 1'b0;
      tx_out_nibble <= 4'h0;
      tx_out_active <= 1'b0;
      low_dibit_reg <= 2'h0;
      tx_phase_reg <= 1'b0;
    end else begin
      tx_out_valid <= 1'b0;
      if (rise_dly_reg[1]) begin
        tx_out_active <= tx_sync_reg[4];
        if (!tx_sync_reg[4]) begin
          tx_phase_reg <= 1'b0;
        end else if (!rmii_mode) begin
          tx_out_valid <= 1'b1;
          tx_out_nibble <= tx_sync_reg[3:0];
        end else if (!tx_phase_reg) begin
          low_dibit_reg <= tx_sync_reg[1:0];
          tx_phase_reg <= 1'b1;
        end else begin
          tx_out_valid <= 1'b1;
          tx_out_nibble <= {tx_sync_reg[1:0], low_dibit_reg};
          tx_phase_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // collision and carrier
  // ****************************************************************
  // rmii has neither pin; drive high as the board pull-ups would
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      collision_in <= 1'b0;
      carrier_sense_in <= 1'b0;
    end else begin
      collision_in <= rmii_mode ? 1'b1 : collision_req;
      carrier_sense_in <= rmii_mode ? 1'b1 : (rx_data_valid || tx_out_active || collision_req);
    end
  end

  // ****************************************************************
  // management data line
  // ****************************************************************
  logic [1:0] mdc_meta_reg;
  logic [1:0] mdc_sync_reg;
  logic mdc_last_reg;

  // first stage feeds only the second
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mdc_meta_reg <= 2'h0;
      mdc_sync_reg <= 2'h0;
      mdc_last_reg <= 1'b0;
    end else begin
      mdc_meta_reg <= {mgmt_clock_out, mgmt_data_io_in};
      mdc_sync_reg <= mdc_meta_reg;
      mdc_last_reg <= mdc_sync_reg[1];
    end
  end

  // latch on mac clock rise; change our drive after its fall for full setup
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mgmt_bit_valid <= 1'b0;
      mgmt_bit <= 1'b0;
      mgmt_data_io_out <= 1'b0;
      mgmt_data_io_oe <= 1'b0;
    end else begin
      mgmt_bit_valid <= mdc_sync_reg[1] && !mdc_last_reg;
      if (mdc_sync_reg[1] && !mdc_last_reg) begin
        mgmt_bit <= mdc_sync_reg[0];
      end
      if (!mdc_sync_reg[1] && mdc_last_reg) begin
        mgmt_data_io_oe <= mgmt_drive_en;
        mgmt_data_io_out <= mgmt_drive_bit;
      end
    end
  end
endmodule

//--- mph_phy_port_checker.sv
// concurrent checks on the pins of the phy-side port
`timescale 1ns/100ps
module mph_phy_port_checker import mph_pkg::*; (
  // clock, reset and mode
  input wire logic core_clk,
  input wire logic reset,
  input wire logic rmii_mode,
  input wire logic slow_speed,
  // medium and link pins
  input wire logic collision_req,
  input wire logic collision_in,
  input wire logic carrier_sense_in,
  input wire logic tx_nibble_clock,
  input wire logic rx_nibble_clock,
  input wire logic [3:0] rx_nibble_bus,
  input wire logic rx_data_valid,
  input wire logic rx_error_in,
  // management
  input wire logic mgmt_clock_out,
  input wire logic mgmt_bit_valid,
  input wire logic mgmt_drive_en,
  input wire logic mgmt_data_io_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // link clock shapes and pin relations
  // ****************************************
  sequence s_fast_rx;
    rx_nibble_clock[*4] ##1 !rx_nibble_clock;
  endsequence
  sequence s_fast_tx;
    tx_nibble_clock[*4] ##1 !tx_nibble_clock;
  endsequence
  a_rx_fast_half: assert property (!rmii_mode && !slow_speed && $rose(rx_nibble_clock) |-> s_fast_rx)
    else $error("fast receive clock half period wrong");
  a_rx_slow_half: assert property (!rmii_mode && slow_speed && $rose(rx_nibble_clock) |-> ##39 rx_nibble_clock ##1 !rx_nibble_clock)
    else $error("slow receive clock half period wrong");
  a_tx_fast_half: assert property (!rmii_mode && !slow_speed && $rose(tx_nibble_clock) |-> s_fast_tx)
    else $error("transmit clock half period wrong");
  a_ref_half: assert property (rmii_mode && $rose(rx_nibble_clock) |-> ##1 rx_nibble_clock ##1 !rx_nibble_clock)
    else $error("reference clock half period wrong");
  a_rmii_pins_idle: assert property (rmii_mode |-> ##2 (collision_in && carrier_sense_in && tx_nibble_clock && rx_nibble_bus[3:2] == 2'h0))
    else $error("rmii unused pins not at rest level");
  a_col_held: assert property ((!rmii_mode && collision_req)[*3] |-> collision_in)
    else $error("collision not shown while present");
  a_col_gone: assert property ((!rmii_mode && !collision_req)[*3] |-> !collision_in)
    else $error("collision shown after it ended");
  a_valid_on_fall: assert property ($changed(rx_data_valid) |-> $fell(rx_nibble_clock))
    else $error("receive valid moved off a falling clock edge");
  a_err_stretch: assert property ($rose(rx_error_in) |-> rx_error_in[*5])
    else $error("receive error too short");
  a_mgmt_sample: assert property ($rose(mgmt_clock_out) |-> ##[2:5] mgmt_bit_valid)
    else $error("management bit not taken after clock rise");
  a_mgmt_drive: assert property ($fell(mgmt_clock_out) && mgmt_drive_en |-> ##[2:5] mgmt_data_io_oe)
    else $error("management drive not enabled after clock fall");
endmodule
bind mph_phy_port mph_phy_port_checker chk (.core_clk, .reset, .rmii_mode, .slow_speed, .collision_req,
  .collision_in, .carrier_sense_in, .tx_nibble_clock, .rx_nibble_clock, .rx_nibble_bus, .rx_data_valid,
  .rx_error_in, .mgmt_clock_out, .mgmt_bit_valid, .mgmt_drive_en, .mgmt_data_io_oe);

//--- mph_phy_port_test.sv
// self-checking bench for the phy-side port
`timescale 1ns/100ps
module mph_phy_port_test import mph_pkg::*; ;
  logic core_clk = 1'b0, reset = 1'b1, rmii_mode = 1'b0, slow_speed = 1'b0, collision_req = 1'b0;
  logic rx_in_valid = 1'b0, rx_in_error = 1'b0, rx_in_last = 1'b0, mgmt_drive_en = 1'b0, mgmt_drive_bit = 1'b0;
  logic [3:0] rx_in_nibble = 4'h0;
  wire rx_in_ready, tx_out_valid, tx_out_active, mgmt_bit_valid, mgmt_bit, mgmt_clock_out, mgmt_data_io_in;
  wire mgmt_data_io_out, mgmt_data_io_oe, tx_enable_out, tx_nibble_clock, rx_nibble_clock, rx_data_valid;
  wire rx_error_in, collision_in, carrier_sense_in;
  wire [3:0] tx_out_nibble, tx_nibble_bus, rx_nibble_bus;
  int miscompares = 0, samples_checked = 0, refused = 0;
  logic [3:0] exp_rx[$], exp_tx[$], got_tx[$];
  logic exp_crc[$], got_mg[$];
  mph_phy_port dut (.core_clk, .reset, .rmii_mode, .slow_speed, .rx_in_valid, .rx_in_ready, .rx_in_nibble,
    .rx_in_error, .rx_in_last, .collision_req, .tx_out_valid, .tx_out_nibble, .tx_out_active, .mgmt_bit_valid,
    .mgmt_bit, .mgmt_drive_en, .mgmt_drive_bit, .mgmt_clock_out, .mgmt_data_io_in, .mgmt_data_io_out,
    .mgmt_data_io_oe, .tx_nibble_bus, .tx_enable_out, .tx_nibble_clock, .rx_nibble_clock, .rx_nibble_bus,
    .rx_data_valid, .rx_error_in, .collision_in, .carrier_sense_in);
  mph_mac_model mac (.core_clk, .rmii_mode, .tx_nibble_clock, .rx_nibble_clock, .rx_nibble_bus, .rx_data_valid,
    .rx_error_in, .tx_nibble_bus, .tx_enable_out, .mgmt_clock_out, .mgmt_data_io_in, .mgmt_data_io_out,
    .mgmt_data_io_oe);
  initial forever #2.5 core_clk = ~core_clk;
  // ****************************************
  // monitors, compare and verdict
  // ****************************************
  always @(posedge core_clk) begin
    if (tx_out_valid === 1'b1) begin
      got_tx.push_back(tx_out_nibble);
      check(4'(tx_out_active), 4'h1, "tx enable seen");
    end
    if (mgmt_bit_valid === 1'b1) got_mg.push_back(mgmt_bit);
    if (rx_in_valid && rx_in_ready === 1'b0) refused++;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] want, input string what);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one word into the buffer; valid held until the edge where ready is high
  task automatic push_word(input logic [3:0] n, input logic e, input logic l);
    int w;
    w = 0;
    @(negedge core_clk) {rx_in_valid, rx_in_nibble, rx_in_error, rx_in_last} = {1'b1, n, e, l};
    while (rx_in_ready !== 1'b1 && w < 4000) begin
      @(negedge core_clk);
      w++;
    end
    @(posedge core_clk);
  endtask
  task automatic send_frame(input int len, input int bad);
    logic [3:0] n;
    for (int i = 0; i < len; i++) begin
      n = 4'($urandom);
      exp_rx.push_back(n);
      push_word(n, i == bad, i == len - 1);
    end
    exp_crc.push_back(bad < len);
    @(negedge core_clk) rx_in_valid = 1'b0;
  endtask
  // one mode: reset, transmit in the background, collision, three frames, then compare all
  task automatic run_mode(input logic rm, input logic sl);
    logic [3:0] n;
    @(negedge core_clk) {reset, rmii_mode, slow_speed} = {1'b1, rm, sl};
    repeat (5) @(negedge core_clk);
    reset = 1'b0;
    repeat (5) begin
      n = 4'($urandom);
      mac.tx_q.push_back(n);
      exp_tx.push_back(n);
    end
    collision_req = 1'b1;
    repeat (6) @(negedge core_clk);
    check(4'(collision_in), 4'h1, "collision pin");
    check(4'(carrier_sense_in), 4'h1, "carrier pin");
    collision_req = 1'b0;
    send_frame(1, 0);
    send_frame(5, 9);
    send_frame(2 + $urandom % 4, $urandom % 6);
    for (int w = 0; w < 20000 && (mac.crc_q.size() < exp_crc.size() || got_tx.size() < exp_tx.size()); w++)
      @(posedge core_clk);
    check(4'(mac.rx_q.size()), 4'(exp_rx.size()), "rx count");
    foreach (exp_rx[i]) check(mac.rx_q[i], exp_rx[i], "rx nibble");
    foreach (exp_crc[i]) check(4'(mac.crc_q[i]), 4'(exp_crc[i]), "crc flag");
    foreach (exp_tx[i]) check(got_tx[i], exp_tx[i], "tx nibble");
    check(4'(mac.bad_end), 4'h0, "odd dibit end");
    check(4'(rx_in_ready), 4'h1, "buffer drained");
    check(4'(tx_out_active), 4'h0, "tx enable idle");
    exp_rx.delete();
    exp_crc.delete();
    exp_tx.delete();
    got_tx.delete();
    mac.rx_q.delete();
    mac.crc_q.delete();
  endtask
  task automatic mgmt_phase;
    logic b;
    logic want[$];
    b = 1'($urandom);
    repeat (6) mac.mg_q.push_back(1'($urandom));
    want = mac.mg_q;
    got_mg.delete();
    @(negedge core_clk) mac.run_mdc = 1'b1;
    repeat (8 * 16) @(negedge core_clk);
    foreach (want[i]) check(4'(got_mg[i + 1]), 4'(want[i]), "mgmt bit in");
    for (int k = 0; k < 2; k++) begin
      @(negedge core_clk) {mgmt_drive_en, mgmt_drive_bit} = {1'b1, b ^ k[0]};
      repeat (4 * 16) @(negedge core_clk);
      check(4'(mac.rd_q[$]), 4'(b ^ k[0]), "mgmt bit out");
      check(4'(got_mg[$]), 4'(b ^ k[0]), "mgmt echo");
    end
    @(negedge core_clk) {mgmt_drive_en, mac.run_mdc} = 2'h0;
  endtask
  initial begin
    void'($urandom(32'h8E822028));
    run_mode(1'b0, 1'b0);
    mgmt_phase();
    run_mode(1'b0, 1'b1);
    run_mode(1'b1, 1'b0);
    check(4'(refused > 0), 4'h1, "buffer refusal");
    wrap_up();
  end
  // watchdog: the full run needs well under this many cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    miscompares++;
    wrap_up();
  end
endmodule

//--- mph_pkg.sv
// types shared by the phy-side port
package mph_pkg;
  typedef enum logic [2:0] {
    MPH_RX_IDLE = 3'b001,
    MPH_RX_SEND = 3'b010,
    MPH_RX_GAP = 3'b100
  } mph_rx_state_t;
endpackage
